// [logic/mfp_regs.svh]
// Register offsets, field positions and reset values of the monitor flag bank
`ifndef MFP_REGS_SVH
`define MFP_REGS_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define MFP_ADDR_ALARM_FIRST    8'h70
`define MFP_ADDR_ALARM_SECOND   8'h71
`define MFP_ADDR_WARN_FIRST     8'h74
`define MFP_ADDR_WARN_SECOND    8'h75
`define MFP_ADDR_PAGE_SELECT    8'h7f

// ------------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------------
`define MFP_NUM_CH              5
`define MFP_CH_TEMP             0
`define MFP_CH_SUPPLY           1
`define MFP_CH_INPUT_A          2
`define MFP_CH_INPUT_B          3
`define MFP_CH_INPUT_C          4
`define MFP_MASK_TEMP_BIT       7
`define MFP_MASK_SUPPLY_BIT     6
`define MFP_MASK_INPUT_A_BIT    5
`define MFP_MASK_INPUT_B_BIT    4
`define MFP_MASK_INPUT_C_BIT    3
`define MFP_PAGE_MSB            1
`define MFP_PAGE_RESET          2'h0
`define MFP_FLAG_RESET          1'h0
`define MFP_BYTE_ZERO           8'h00
`define MFP_SPARE_SECOND        5'h00
`define MFP_SPARE_WARN          6'h00
`define MFP_PAGE_SPARE          6'h00

`endif

// [logic/mfp_pkg.sv]
// Types shared by the monitor flag bank modules
package mfp_pkg;

   typedef logic [7:0] mfp_byte_t;
   typedef logic [1:0] mfp_page_t;
   typedef logic [4:0] mfp_chvec_t;

   // State of one hi/lo flag pair
   typedef struct packed
   {
      logic hi;
      logic lo;
   } mfp_pair_t;

   // State of the top level
   typedef struct packed
   {
      mfp_page_t page;
      logic      irq;
      mfp_byte_t rdata;
   } mfp_top_t;

endpackage : mfp_pkg

// [logic/mfp_flag_pair.sv]
// One upper/lower limit flag pair, refreshed by each conversion result
`timescale 1ns/10ps
`default_nettype none
`include "mfp_regs.svh"

module mfp_flag_pair
(
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   // Comparison result of a finished conversion
   input  wire logic update_in,
   input  wire logic over_in,
   input  wire logic under_in,
   // Flags
   output logic      over_out,
   output logic      under_out
);
   import mfp_pkg::*;

   mfp_pair_t state_ff;
   mfp_pair_t nxt_state;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Flags mirror only the latest comparison, so they are not sticky
   always_comb
   begin
      nxt_state = state_ff;
      if (update_in)
      begin
         nxt_state.hi = over_in;
         nxt_state.lo = under_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_ff.hi <= `MFP_FLAG_RESET;
         state_ff.lo <= `MFP_FLAG_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign over_out  = state_ff.hi;
   assign under_out = state_ff.lo;

endmodule // mfp_flag_pair

`default_nettype wire

// [logic/mfp_monitor_flags.sv]
// Alarm and warning flag bytes, masked interrupt and table select register
//
// Summary of operation
// - Supply alarm: over bit 5, under bit 4
// - Input A alarm: over bit 3, under 2
// - Input B alarm: over bit 1, under 0
// - Input C alarm: second byte bits 7, 6
// - Masked interrupt bit from enabled flags
// - Temperature warning: over bit 7, under 6
// - Supply warning: over bit 5, under 4
// - Input A warning: over bit 3, under 2
// - Input B warning: over bit 1, under 0
// - Input C warning bits 7, 6; rest zero
// - Two select bits pick upper table
// - Buffer one output follows masked interrupt
`timescale 1ns/10ps
`default_nettype none
`include "mfp_regs.svh"

module mfp_monitor_flags
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // Comparator results from the conversion engine, one bit per channel
   input  wire logic [4:0]  conv_done_in,
   input  wire logic [4:0]  alarm_over_in,
   input  wire logic [4:0]  alarm_under_in,
   input  wire logic [4:0]  warn_over_in,
   input  wire logic [4:0]  warn_under_in,
   // Interrupt enable mask byte held in nonvolatile storage
   input  wire mfp_pkg::mfp_byte_t int_enable_mask_in,
   // Register port of the serial interface engine
   input  wire logic [7:0]  reg_addr_in,
   input  wire mfp_pkg::mfp_byte_t reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output mfp_pkg::mfp_byte_t reg_rdata_out,
   // Table select and interrupt
   output mfp_pkg::mfp_page_t page_select_out,
   output logic             masked_interrupt_flag_out,
   // Open-drain buffer one pin
   output logic             buf1_pin_out,
   output logic             buf1_pin_oe_out
);
   import mfp_pkg::*;

   mfp_top_t   state_ff;
   mfp_top_t   nxt_state;
   mfp_chvec_t alarm_over;
   mfp_chvec_t alarm_under;
   mfp_chvec_t warn_over;
   mfp_chvec_t warn_under;
   mfp_chvec_t ch_enable;
   mfp_byte_t  alarm_first;
   mfp_byte_t  alarm_second;
   mfp_byte_t  warn_first;
   mfp_byte_t  warn_second;
   logic       irq_now;
   logic       page_wr;

   // Value of every top-level state register while reset is held
   localparam mfp_top_t RESET_STATE = '{page:  `MFP_PAGE_RESET,
                                        irq:   `MFP_FLAG_RESET,
                                        rdata: `MFP_BYTE_ZERO};

   // ------------------------------------------------------------------
   // Flag storage, one pair per channel for alarm and for warning
   // ------------------------------------------------------------------
   genvar ch;
   // Alarm and warning flags of a channel share one conversion strobe
   // Flag pairs hold their own reset, outside the top state
   generate
      for (ch = 0; ch < `MFP_NUM_CH; ch = ch + 1)
      begin : g_ch
         mfp_flag_pair u_alarm
         (
            .clk_in    (clk_in),
            .rst_b_in  (rst_b_in),
            .update_in (conv_done_in[ch]),
            .over_in   (alarm_over_in[ch]),
            .under_in  (alarm_under_in[ch]),
            .over_out  (alarm_over[ch]),
            .under_out (alarm_under[ch])
         );
         mfp_flag_pair u_warn
         (
            .clk_in    (clk_in),
            .rst_b_in  (rst_b_in),
            .update_in (conv_done_in[ch]),
            .over_in   (warn_over_in[ch]),
            .under_in  (warn_under_in[ch]),
            .over_out  (warn_over[ch]),
            .under_out (warn_under[ch])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Flag byte packing
   // ------------------------------------------------------------------
   function automatic logic [1:0] pair_of(input mfp_chvec_t ov, input mfp_chvec_t un,
                                          input int idx);
      pair_of = {ov[idx], un[idx]};
   endfunction

   // Temperature alarm fills bits 7 and 6 beside the documented pairs
   assign alarm_first = {pair_of(alarm_over, alarm_under, `MFP_CH_TEMP),
                         pair_of(alarm_over, alarm_under, `MFP_CH_SUPPLY),
                         pair_of(alarm_over, alarm_under, `MFP_CH_INPUT_A),
                         pair_of(alarm_over, alarm_under, `MFP_CH_INPUT_B)};

   assign alarm_second = {pair_of(alarm_over, alarm_under, `MFP_CH_INPUT_C),
                          `MFP_SPARE_SECOND, state_ff.irq};

   // Warning bytes reuse the alarm layout, except bit 0 of the second byte reads zero instead of the masked interrupt

   assign warn_first = {pair_of(warn_over, warn_under, `MFP_CH_TEMP),
                        pair_of(warn_over, warn_under, `MFP_CH_SUPPLY),
                        pair_of(warn_over, warn_under, `MFP_CH_INPUT_A),
                        pair_of(warn_over, warn_under, `MFP_CH_INPUT_B)};

   assign warn_second = {pair_of(warn_over, warn_under, `MFP_CH_INPUT_C),
                         `MFP_SPARE_WARN};

   // ------------------------------------------------------------------
   // Masked interrupt
   // ------------------------------------------------------------------
   // Software enables sources one by one; a clear mask silences everything
   // Mask bit that belongs to each channel; mask bits 2 to 0 are spare
   function automatic int mask_bit_of(input int idx);
      unique case (idx)
         `MFP_CH_TEMP:    mask_bit_of = `MFP_MASK_TEMP_BIT;
         `MFP_CH_SUPPLY:  mask_bit_of = `MFP_MASK_SUPPLY_BIT;
         `MFP_CH_INPUT_A: mask_bit_of = `MFP_MASK_INPUT_A_BIT;
         `MFP_CH_INPUT_B: mask_bit_of = `MFP_MASK_INPUT_B_BIT;
         default:         mask_bit_of = `MFP_MASK_INPUT_C_BIT;
      endcase
   endfunction

   // Channel enables, one mask bit each
   generate
      for (ch = 0; ch < `MFP_NUM_CH; ch = ch + 1)
      begin : g_en
         assign ch_enable[ch] = int_enable_mask_in[mask_bit_of(ch)];
      end
   endgenerate

   // Alarm and warning flags of an enabled channel both raise the interrupt
   assign irq_now = |(ch_enable & (alarm_over | alarm_under | warn_over | warn_under));

   // ------------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------------
   function automatic mfp_byte_t read_mux(input logic [7:0] addr);
      unique case (addr)
         `MFP_ADDR_ALARM_FIRST:  read_mux = alarm_first;
         `MFP_ADDR_ALARM_SECOND: read_mux = alarm_second;
         `MFP_ADDR_WARN_FIRST:   read_mux = warn_first;
         `MFP_ADDR_WARN_SECOND:  read_mux = warn_second;
         `MFP_ADDR_PAGE_SELECT:  read_mux = {`MFP_PAGE_SPARE, state_ff.page};
         // Reserved and unmapped addresses read as zero
         default:                read_mux = `MFP_BYTE_ZERO;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Register write decode
   // ------------------------------------------------------------------
   // Only the table select takes writes; flag bytes are results only
   assign page_wr = reg_wr_in && (reg_addr_in == `MFP_ADDR_PAGE_SELECT);

   // Bits 7 to 2 of a table select write are spare and dropped here
   function automatic mfp_page_t page_code_of(input mfp_byte_t wdata);
      page_code_of = wdata[`MFP_PAGE_MSB:0];
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // A read in the same cycle as a write returns the old table code
   always_comb
   begin
      nxt_state     = state_ff;
      nxt_state.irq = irq_now;
      if (page_wr)
      begin
         nxt_state.page = page_code_of(reg_wdata_in);
      end
      // Captured on the strobe so the byte stays put between reads
      if (reg_rd_in)
      begin
         nxt_state.rdata = read_mux(reg_addr_in);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_ff <= RESET_STATE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Read data holds until the next read strobe, so the engine may fetch it late
   assign reg_rdata_out             = state_ff.rdata;
   assign page_select_out           = state_ff.page;
   assign masked_interrupt_flag_out = state_ff.irq;
   // Open-drain: pull low while the interrupt stands, release otherwise
   assign buf1_pin_out              = 1'b0;
   assign buf1_pin_oe_out           = state_ff.irq;

endmodule // mfp_monitor_flags

`default_nettype wire

// [verification/mfp_flags_props.sv]
// Checker of the monitor flag bank ports
`timescale 1ns/10ps
`default_nettype none
module mfp_flags_props
(
   // Watched ports
   input wire logic               clk_in,
   input wire logic               rst_b_in,
   input wire logic [4:0]         conv_done_in,
   input wire logic [4:0]         alarm_over_in,
   input wire mfp_pkg::mfp_byte_t int_enable_mask_in,
   input wire logic [7:0]         reg_addr_in,
   input wire mfp_pkg::mfp_byte_t reg_wdata_in,
   input wire logic               reg_wr_in,
   input wire logic               reg_rd_in,
   input wire mfp_pkg::mfp_byte_t reg_rdata_out,
   input wire mfp_pkg::mfp_page_t page_select_out,
   input wire logic               masked_interrupt_flag_out,
   input wire logic               buf1_pin_out,
   input wire logic               buf1_pin_oe_out
);
   logic [1:0] wr_low;
   assign wr_low = reg_wdata_in[1:0];
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   chk_oe_irq: assert property (buf1_pin_oe_out == masked_interrupt_flag_out)
      else $error("pin enable differs from interrupt bit");
   chk_pin_low: assert property (buf1_pin_out == 1'b0)
      else $error("open drain data not low");
   chk_mask_off: assert property (int_enable_mask_in == 8'h00
      |=> !masked_interrupt_flag_out)
      else $error("interrupt set with empty mask");
   chk_spare_mask: assert property (int_enable_mask_in[7:3] == 5'h00
      |=> !masked_interrupt_flag_out)
      else $error("spare mask bits raised interrupt");
   chk_irq_rise: assert property (conv_done_in[1] && alarm_over_in[1]
      ##1 int_enable_mask_in[6] |=> masked_interrupt_flag_out)
      else $error("enabled flag gave no interrupt");
   chk_flag_read: assert property (conv_done_in[1] && alarm_over_in[1]
      ##1 !conv_done_in[1] ##1 reg_rd_in && reg_addr_in == 8'h70 |=> reg_rdata_out[5])
      else $error("supply over flag not read back");
   chk_page_write: assert property (reg_wr_in && reg_addr_in == 8'h7f
      |=> page_select_out == $past(wr_low))
      else $error("table select not written");
   chk_page_hold: assert property (!(reg_wr_in && reg_addr_in == 8'h7f)
      |=> $stable(page_select_out))
      else $error("table select changed unasked");
   chk_warn_spare: assert property (reg_rd_in && reg_addr_in == 8'h75
      |=> reg_rdata_out[5:0] == 6'h00)
      else $error("unused warning bits not zero");
   chk_sel_read: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 8'h7f
      |=> reg_rdata_out == {6'h00, $past(page_select_out)})
      else $error("table select read wrong");
   cov_irq: cover property ($rose(masked_interrupt_flag_out));
   cov_page: cover property (reg_wr_in && reg_addr_in == 8'h7f);
   cov_flag: cover property (reg_rd_in && reg_addr_in == 8'h74);
endmodule // mfp_flags_props
bind mfp_monitor_flags mfp_flags_props u_props (.clk_in, .rst_b_in, .conv_done_in,
   .alarm_over_in, .int_enable_mask_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
   .reg_rd_in, .reg_rdata_out, .page_select_out, .masked_interrupt_flag_out,
   .buf1_pin_out, .buf1_pin_oe_out);
`default_nettype wire

// [verification/mfp_host_model.sv]
// Host model that masters the register port
`timescale 1ns/10ps
`default_nettype none
module mfp_host_model
(
   // Clock
   input  wire logic               clk_in,
   // Register port
   output logic [7:0]              reg_addr_out,
   output mfp_pkg::mfp_byte_t      reg_wdata_out,
   output logic                    reg_wr_out,
   output logic                    reg_rd_out,
   input  wire mfp_pkg::mfp_byte_t reg_rdata_in
);
   import mfp_pkg::*;
   initial
   begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
   end
   // Idle lines show the inverse, so a stale address is never reused
   task automatic access(input logic [7:0] a, input mfp_byte_t d, input logic w,
                         output mfp_byte_t q);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= w;
      reg_rd_out <= !w;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
      #1;
      q = reg_rdata_in;
   endtask
endmodule // mfp_host_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking testbench of the monitor flag bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import mfp_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_b_in = 1'b0;
   logic [4:0] done = '0, a_hi = '0, a_lo = '0, w_hi = '0, w_lo = '0;
   mfp_byte_t  mask = '0, wdata, q;
   logic [7:0] addr;
   logic       wr, rd, irq, pin, oe;
   mfp_byte_t  rdata;
   mfp_page_t  page;
   logic [7:0] regs [5] = '{8'h70, 8'h71, 8'h74, 8'h75, 8'h7f};
   int         num_errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   always #5 clk_in = ~clk_in;
   mfp_monitor_flags u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .conv_done_in(done),
      .alarm_over_in(a_hi), .alarm_under_in(a_lo), .warn_over_in(w_hi),
      .warn_under_in(w_lo), .int_enable_mask_in(mask), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .page_select_out(page), .masked_interrupt_flag_out(irq), .buf1_pin_out(pin),
      .buf1_pin_oe_out(oe));
   mfp_host_model u_host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wdata_out(wdata),
      .reg_wr_out(wr), .reg_rd_out(rd), .reg_rdata_in(rdata));
   task automatic chk(input string n, input mfp_byte_t e, input mfp_byte_t g);
      cmp_count++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic convert(input logic [4:0] ah, al, wh, wl);
      @(posedge clk_in);
      done <= 5'h1f;
      a_hi <= ah;
      a_lo <= al;
      w_hi <= wh;
      w_lo <= wl;
      @(posedge clk_in);
      done <= 5'h00;
   endtask
   task automatic set_mask(input mfp_byte_t m, input mfp_byte_t e);
      @(posedge clk_in);
      mask <= m;
      repeat (2) @(posedge clk_in);
      #1;
      chk("interrupt", e, {7'h00, irq});
      chk("buffer data", 8'h00, {7'h00, pin});
      chk("buffer enable", e, {7'h00, oe});
   endtask
   task automatic t_reset;
      foreach (regs[i])
      begin
         u_host.access(regs[i], 8'h00, 1'b0, q);
         chk("reset value", 8'h00, q);
      end
   endtask
   task automatic t_flags;
      logic [9:0] f;
      logic [4:0] v;
      for (int k = 0; k < 20; k++)
      begin
         v = 5'h01 << (k / 4);
         f = 10'h200 >> (2 * (k / 4) + k % 2);
         convert(k % 4 == 0 ? v : 5'h0, k % 4 == 1 ? v : 5'h0, k % 4 == 2 ? v : 5'h0,
                 k % 4 == 3 ? v : 5'h0);
         u_host.access(k % 4 > 1 ? 8'h74 : 8'h70, 8'h00, 1'b0, q);
         chk("first flag byte", f[9:2], q);
         u_host.access(k % 4 > 1 ? 8'h75 : 8'h71, 8'h00, 1'b0, q);
         chk("second flag byte", {f[1:0], 6'h00}, q);
      end
   endtask
   task automatic t_masked_interrupt_flag;
      set_mask(8'h07, 8'h00);
      for (int ch = 0; ch < 5; ch++)
      begin
         convert(5'h0, 5'h0, 5'h0, 5'h01 << ch);
         set_mask(8'h80 >> ((ch + 1) % 5), 8'h00);
         set_mask(8'h80 >> ch, 8'h01);
         u_host.access(8'h71, 8'h00, 1'b0, q);
         chk("masked bit", 8'h01, q);
         convert(5'h01 << ch, 5'h0, 5'h0, 5'h0);
         set_mask(8'h80 >> ch, 8'h01);
         convert(5'h0, 5'h0, 5'h0, 5'h0);
         set_mask(8'h80 >> ch, 8'h00);
         set_mask(8'h00, 8'h00);
      end
   endtask
   task automatic t_ro;
      convert(5'h01, 5'h0, 5'h0, 5'h0);
      for (int i = 0; i < 4; i++)
         u_host.access(regs[i], 8'hff, 1'b1, q);
      u_host.access(8'h70, 8'h00, 1'b0, q);
      chk("alarm after write", 8'h80, q);
      u_host.access(8'h72, 8'h00, 1'b0, q);
      chk("unmapped read", 8'h00, q);
      chk("table after flag writes", 8'h00, {6'h00, page});
   endtask
   task automatic t_page;
      for (int c = 3; c >= 0; c--)
      begin
         u_host.access(8'h7f, 8'hfc | 8'(c), 1'b1, q);
         u_host.access(8'h7f, 8'h00, 1'b0, q);
         chk("table select", 8'(c), q);
         chk("table output", 8'(c), {6'h00, page});
      end
   endtask
   task automatic t_rst_mid;
      u_host.access(8'h7f, 8'h02, 1'b1, q);
      convert(5'h01, 5'h0, 5'h0, 5'h0);
      set_mask(8'h80, 8'h01);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      #1;
      chk("table output after reset", 8'h00, {6'h00, page});
      chk("buffer enable after reset", 8'h00, {7'h00, oe});
      u_host.access(8'h7f, 8'h00, 1'b0, q);
      chk("table select after reset", 8'h00, q);
      set_mask(8'h00, 8'h00);
   endtask
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_reset;
      t_flags;
      t_masked_interrupt_flag;
      t_ro;
      t_page;
      t_rst_mid;
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
